// ---- logic/tswdt_low_speed_clock_tick.sv ----
// module: low-speed clock synchroniser, edge detect and divide-by-128 tick
`timescale 1ns/1ps
module tswdt_low_speed_clock_tick
    import tswdt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic lowSpeedClock,
    input wire logic countRun,
    output logic dividedCountTick,
    output logic lsFall
);

    logic lsMeta_q;
    logic lsSync_q;
    logic lsPrev_q;
    logic lsRise;
    logic [TSWDT_PRESCALE_W-1:0] prescale_q;

    // ************************************************************
    // synchroniser: the pin is asynchronous to clk
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            lsMeta_q <= 1'b0;
            lsSync_q <= 1'b0;
            lsPrev_q <= 1'b0;
        end else begin
            lsMeta_q <= lowSpeedClock;
            lsSync_q <= lsMeta_q;
            lsPrev_q <= lsSync_q;
        end
    end

    assign lsRise = lsSync_q && !lsPrev_q;

    // ************************************************************
    // prescaler: a stopped low-speed clock simply freezes it
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            prescale_q <= '0;
        end else if (countRun && lsRise) begin
            prescale_q <= prescale_q + TSWDT_PRESCALE_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dividedCountTick <= 1'b0;
            lsFall <= 1'b0;
        end else begin
            dividedCountTick <= countRun && lsRise && (prescale_q == TSWDT_PRESCALE_LAST);
            lsFall <= lsPrev_q && !lsSync_q;
        end
    end

    a_tick_after_wrap: assert property (@(posedge clk) disable iff (rst)
        dividedCountTick |-> prescale_q == '0)
        else $error("tick without prescaler wrap");

    a_tick_gated_off: assert property (@(posedge clk) disable iff (rst)
        !countRun |=> !dividedCountTick)
        else $error("tick while counting is stopped");

endmodule // tswdt_low_speed_clock_tick

// ---- logic/tswdt_pkg.sv ----
// package: constants, types and carriers for the two-stage watchdog timer
package tswdt_pkg;

    // ************************************************************
    // register map: printed offsets are indices, byte address = 4 x index
    // ************************************************************
    localparam logic [31:0] TSWDT_IDX_CLEAR_KEY = 32'h0000f00e;
    localparam logic [31:0] TSWDT_IDX_PERIOD_SEL = 32'h0000f00f;
    localparam logic [31:0] TSWDT_IDX_STATUS = 32'h0000f010;
    localparam logic [31:0] TSWDT_ADDR_CLEAR_KEY = TSWDT_IDX_CLEAR_KEY << 2;
    localparam logic [31:0] TSWDT_ADDR_PERIOD_SEL = TSWDT_IDX_PERIOD_SEL << 2;
    localparam logic [31:0] TSWDT_ADDR_STATUS = TSWDT_IDX_STATUS << 2;

    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam logic [7:0] TSWDT_PERIOD_SEL_RESET = 8'h82;
    localparam int TSWDT_DEEP_SLEEP_STATE_EN_BIT = 7;
    localparam int TSWDT_PERIOD_LSB = 0;
    localparam int TSWDT_PERIOD_W = 2;
    localparam logic [7:0] TSWDT_KEY_FIRST = 8'h5a;
    localparam logic [7:0] TSWDT_KEY_SECOND = 8'ha5;
    localparam int TSWDT_STATUS_STATE_LSB = 0;
    localparam int TSWDT_STATUS_COUNT_LSB = 16;

    // ************************************************************
    // timing: low-speed clock divided by 128 feeds the counter
    // ************************************************************
    localparam int TSWDT_PRESCALE_DIV = 128;
    localparam int TSWDT_PRESCALE_W = $clog2(TSWDT_PRESCALE_DIV);
    localparam logic [TSWDT_PRESCALE_W-1:0] TSWDT_PRESCALE_LAST =
        TSWDT_PRESCALE_W'(TSWDT_PRESCALE_DIV - 1);
    localparam int TSWDT_COUNT_W = 12;
    // overflow periods in divided ticks (4096/16384/65536/262144 low-speed counts)
    localparam logic [TSWDT_COUNT_W-1:0] TSWDT_LIMIT_00 = 12'h020;
    localparam logic [TSWDT_COUNT_W-1:0] TSWDT_LIMIT_01 = 12'h080;
    localparam logic [TSWDT_COUNT_W-1:0] TSWDT_LIMIT_10 = 12'h200;
    localparam logic [TSWDT_COUNT_W-1:0] TSWDT_LIMIT_11 = 12'h800;
    localparam logic [TSWDT_COUNT_W-1:0] TSWDT_COUNT_STEP = 12'h001;

    // ************************************************************
    // ahb-lite encodings
    // ************************************************************
    localparam logic [1:0] TSWDT_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] TSWDT_HTRANS_SEQ = 2'h3;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_INIT = 2'b01,
        ST_WARNED = 2'b11,
        ST_RESET = 2'b10
    } tswdt_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic keySel;
        logic periodSel;
    } tswdt_aphase_t;

endpackage

// ---- logic/tswdt_top.sv ----
// module: two-stage watchdog timer with ahb-lite register slave
// Function
// - counting starts by itself after reset release
// - 5a at pointer 0, a5 at 1 clears
// - pointer forced to 0 on reset, overflow
// - every key-register write outside the hold and the overflow cycle toggles the pointer
// - overflow without clear raises warning interrupt
// - warning only on first overflow since clear
// - second overflow asserts watchdog reset request
// - period select: 4096/16384/65536/262144 low-speed counts
// - counter advances on low-speed clock divided 128
// - half low-speed period after warning: hold, ignore
// - no counting in stop mode
// - warning interrupt wakes all halt modes
// - watchdog can never be stopped or disabled
// - key-register read gives pointer in bit 0
// - wrong key for pointer state never clears
// - deep_sleep_state enable bit: count or pause
// - warning is a non-maskable interrupt request
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
module tswdt_top
    import tswdt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic lowSpeedClock,
    input wire logic stopMode,
    input wire logic deepSleepState,
    output logic overflowWarningInterrupt,
    output logic haltWakeRequest,
    output logic watchdogResetRequest
);

    // ************************************************************
    // declarations
    // ************************************************************
    tswdt_aphase_t aphase_d;
    tswdt_aphase_t aphase_q;
    tswdt_state_t state_q;
    tswdt_state_t state_d;
    logic [7:0] periodSel_q;
    logic keyWritePointer_q;
    logic keyArmed_q;
    logic [TSWDT_COUNT_W-1:0] wdtCount_q;
    logic [TSWDT_COUNT_W-1:0] periodLimit;
    logic [TSWDT_COUNT_W-1:0] countNext;
    logic [31:0] hrdata_q;
    logic warnIrq_q;
    logic wdtReset_q;
    logic countRun;
    logic dividedCountTick;
    logic lsFall;
    logic ovfEvt;
    logic keyWr;
    logic keyAccepted;
    logic clearEvt;
    logic [7:0] wrByte;
    logic deepHaltCountEnable;
    logic [TSWDT_PERIOD_W-1:0] periodSelect;

    // ************************************************************
    // ahb-lite slave: zero wait states, always okay
    // ************************************************************
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_comb begin
        aphase_d = '0;
        aphase_d.valid = hsel && hready &&
            (htrans == TSWDT_HTRANS_NONSEQ || htrans == TSWDT_HTRANS_SEQ);
        aphase_d.write = hwrite;
        aphase_d.keySel = (haddr == TSWDT_ADDR_CLEAR_KEY);
        aphase_d.periodSel = (haddr == TSWDT_ADDR_PERIOD_SEL);
    end

    // hsize is not checked: every register is a single word slot
    always_ff @(posedge clk) begin
        if (rst) begin
            aphase_q <= '0;
        end else if (hready) begin
            aphase_q <= aphase_d;
        end
    end

    // read data is prepared at the address edge so it is a flip-flop
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata_q <= '0;
        end else if (aphase_d.valid && !hwrite) begin
            hrdata_q <= '0;
            if (aphase_d.keySel) begin
                hrdata_q[0] <= keyWritePointer_q;
            end else if (aphase_d.periodSel) begin
                hrdata_q[7:0] <= periodSel_q;
            end else if (haddr == TSWDT_ADDR_STATUS) begin
                hrdata_q[TSWDT_STATUS_STATE_LSB +: 2] <= state_q;
                hrdata_q[TSWDT_STATUS_COUNT_LSB +: TSWDT_COUNT_W] <= wdtCount_q;
            end
        end
    end

    assign wrByte = hwdata[7:0];
    assign keyWr = aphase_q.valid && aphase_q.write && aphase_q.keySel;

    // ************************************************************
    // mode register: period select and deep_sleep_state count enable
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            periodSel_q <= TSWDT_PERIOD_SEL_RESET;
        end else if (aphase_q.valid && aphase_q.write && aphase_q.periodSel) begin
            periodSel_q <= wrByte;
        end
    end

    assign deepHaltCountEnable = periodSel_q[TSWDT_DEEP_SLEEP_STATE_EN_BIT];
    assign periodSelect = periodSel_q[TSWDT_PERIOD_LSB +: TSWDT_PERIOD_W];

    always_comb begin
        case (periodSelect)
            2'h0: periodLimit = TSWDT_LIMIT_00;
            2'h1: periodLimit = TSWDT_LIMIT_01;
            2'h2: periodLimit = TSWDT_LIMIT_10;
            2'h3: periodLimit = TSWDT_LIMIT_11;
            default: periodLimit = TSWDT_LIMIT_11;
        endcase
    end

    // ************************************************************
    // count tick: no enable bit exists, only stop and deep_sleep_state pause it
    // ************************************************************
    assign countRun = !stopMode && !(deepSleepState && !deepHaltCountEnable);

    tswdt_low_speed_clock_tick u_tick (
        .clk(clk),
        .rst(rst),
        .lowSpeedClock(lowSpeedClock),
        .countRun(countRun),
        .dividedCountTick(dividedCountTick),
        .lsFall(lsFall)
    );

    assign countNext = wdtCount_q + TSWDT_COUNT_STEP;
    // a shortened period takes effect at once, hence >= rather than ==
    assign ovfEvt = dividedCountTick && (countNext >= periodLimit) &&
        (state_q == ST_RUN || state_q == ST_WARNED);

    // ************************************************************
    // key sequence
    // ************************************************************
    assign keyAccepted = keyWr && (state_q != ST_INIT) && !ovfEvt;
    assign clearEvt = keyAccepted && keyWritePointer_q && keyArmed_q &&
        (wrByte == TSWDT_KEY_SECOND);

    always_ff @(posedge clk) begin
        if (rst) begin
            keyWritePointer_q <= 1'b0;
        end else if (ovfEvt || state_q == ST_INIT) begin
            keyWritePointer_q <= 1'b0;
        end else if (keyAccepted) begin
            keyWritePointer_q <= !keyWritePointer_q;
        end
    end

    // first key must land while the pointer is 0
    always_ff @(posedge clk) begin
        if (rst) begin
            keyArmed_q <= 1'b0;
        end else if (ovfEvt || state_q == ST_INIT) begin
            keyArmed_q <= 1'b0;
        end else if (keyAccepted) begin
            keyArmed_q <= !keyWritePointer_q && (wrByte == TSWDT_KEY_FIRST);
        end
    end

    // ************************************************************
    // counter
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            wdtCount_q <= '0;
        end else if (ovfEvt || state_q == ST_INIT || state_q == ST_RESET) begin
            wdtCount_q <= '0;
        end else if (clearEvt) begin
            wdtCount_q <= '0;
        end else if (dividedCountTick) begin
            wdtCount_q <= countNext;
        end
    end

    // ************************************************************
    // overflow stages
    // ************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (ovfEvt) begin
                    state_d = ST_INIT;
                end
            end
            ST_INIT: begin
                // the low-speed falling edge ends the half-period hold
                if (lsFall) begin
                    state_d = ST_WARNED;
                end
            end
            ST_WARNED: begin
                if (ovfEvt) begin
                    state_d = ST_RESET;
                end else if (clearEvt) begin
                    state_d = ST_RUN;
                end
            end
            ST_RESET: begin
                state_d = ST_RESET;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // outputs: warning pulse is non-maskable and also wakes halt modes
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            warnIrq_q <= 1'b0;
        end else begin
            warnIrq_q <= ovfEvt && (state_q == ST_RUN);
        end
    end

    // held until the system reset it triggers comes back in on rst
    always_ff @(posedge clk) begin
        if (rst) begin
            wdtReset_q <= 1'b0;
        end else if (ovfEvt && state_q == ST_WARNED) begin
            wdtReset_q <= 1'b1;
        end
    end

    assign overflowWarningInterrupt = warnIrq_q;
    assign haltWakeRequest = warnIrq_q;
    assign watchdogResetRequest = wdtReset_q;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_ptr_on_ovf: assert property (
        ovfEvt |=> !keyWritePointer_q)
        else $error("pointer not zero after overflow");

    a_ptr_toggles: assert property (
        keyAccepted |=> keyWritePointer_q != $past(keyWritePointer_q))
        else $error("pointer did not toggle on key write");

    a_init_hold: assert property (
        state_q == ST_INIT |=> !keyWritePointer_q && wdtCount_q == '0)
        else $error("counter or pointer moved during hold");

    a_init_ignore: assert property (
        keyWr && state_q == ST_INIT |-> !keyAccepted && !clearEvt)
        else $error("key write taken during hold");

    a_clear_zero: assert property (
        clearEvt && !ovfEvt |=> wdtCount_q == '0 && !keyWritePointer_q)
        else $error("clear did not zero the counter");

    a_wrong_key: assert property (
        keyWr && !keyWritePointer_q |-> !clearEvt)
        else $error("clear with pointer at zero");

    a_first_warn: assert property (
        ovfEvt && state_q == ST_RUN |=> overflowWarningInterrupt && !watchdogResetRequest
            ##1 !overflowWarningInterrupt)
        else $error("first overflow did not give one warning pulse");

    a_warn_only_first: assert property (
        overflowWarningInterrupt |-> $past(state_q) == ST_RUN && state_q == ST_INIT)
        else $error("warning outside first overflow");

    a_second_reset: assert property (
        ovfEvt && state_q == ST_WARNED |=> watchdogResetRequest [*3])
        else $error("second overflow did not hold reset request");

    a_period_ovf: assert property (
        dividedCountTick && state_q == ST_RUN && countNext >= periodLimit |=> state_q == ST_INIT)
        else $error("overflow missed at selected period");

    a_stop_freeze: assert property (
        stopMode && $past(stopMode) && !clearEvt && state_q != ST_INIT |=> $stable(wdtCount_q))
        else $error("counter moved in stop mode");

    a_wake_irq: assert property (
        haltWakeRequest == overflowWarningInterrupt)
        else $error("wake request differs from warning");

    a_deep_pause: assert property (
        deepSleepState && !deepHaltCountEnable |=> !dividedCountTick)
        else $error("counting in deep sleep while disabled");

    // only the low-speed falling edge may end the hold
    a_hold_exit: assert property (
        state_q == ST_INIT && !lsFall |=> state_q == ST_INIT)
        else $error("hold state left too early");

    a_reset_only_warned: assert property (
        state_q != ST_WARNED && !watchdogResetRequest |=> !watchdogResetRequest)
        else $error("reset request outside warned stage");

    a_count_step: assert property (
        dividedCountTick && state_q == ST_RUN && !ovfEvt && !clearEvt
            |=> wdtCount_q == $past(wdtCount_q) + TSWDT_COUNT_STEP)
        else $error("counter did not advance on tick");

endmodule // tswdt_top

// ---- verification/tb_tswdt_top.sv ----
// testbench: self-checking bench for the two-stage watchdog timer
`timescale 1ns/1ps
module tb_tswdt_top
    import tswdt_pkg::*;
    ;
    // ************************************************************
    // signals and bench model state
    // ************************************************************
    logic clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic lowSpeedClock = 1'b0;
    logic stopMode, deepSleepState;
    logic overflowWarningInterrupt, haltWakeRequest, watchdogResetRequest;
    logic lsFreeze, mPtr, mHold;
    int lsCnt = 0;
    int nMismatch, checksDone;

    assign hready = hreadyout;

    tswdt_top uut (
        .clk(clk),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .lowSpeedClock(lowSpeedClock),
        .stopMode(stopMode),
        .deepSleepState(deepSleepState),
        .overflowWarningInterrupt(overflowWarningInterrupt),
        .haltWakeRequest(haltWakeRequest),
        .watchdogResetRequest(watchdogResetRequest)
    );

    // ************************************************************
    // clocks: low-speed clock is 6 clk high, 4 clk low, so the tick
    // comes 1280 clk apart; freezing it high stretches the hold state
    // 6 high is the least that lets the freeze land before the fall
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (!(lsFreeze && lowSpeedClock)) begin
            if (lsCnt >= (lowSpeedClock ? 5 : 3)) begin
                lsCnt <= 0;
                lowSpeedClock <= ~lowSpeedClock;
            end else begin
                lsCnt <= lsCnt + 1;
            end
        end
    end

    // ************************************************************
    // compare, verdict and bus tasks
    // ************************************************************
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            nMismatch++;
            $display("[ERR] wait limit expected below %0d seen %0d", lim, n);
            give_verdict();
        end
    endtask

    // single whole-word transfer; the master holds each phase until hready is seen
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= TSWDT_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        bound(n, 100);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        bound(n, 100);
        q = hrdata;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        ahb(1'b0, a, 32'h0, q);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    // model: every key write toggles the pointer unless the hold state is on
    task automatic wrKey(input logic [31:0] d);
        wr(TSWDT_ADDR_CLEAR_KEY, d);
        if (!mHold) mPtr = ~mPtr;
    endtask

    task automatic chkPtr();
        logic [31:0] q;
        rd(TSWDT_ADDR_CLEAR_KEY, q);
        cmp("key pointer", {31'h0, mPtr}, q);
    endtask

    task automatic rdCnt(output logic [11:0] c);
        logic [31:0] q;
        rd(TSWDT_ADDR_STATUS, q);
        c = q[TSWDT_STATUS_COUNT_LSB +: TSWDT_COUNT_W];
    endtask

    task automatic chkStage(input logic [1:0] s);
        logic [31:0] q;
        rd(TSWDT_ADDR_STATUS, q);
        cmp("stage", {30'h0, s}, {30'h0, q[1:0]});
    endtask

    task automatic nextTick(output time t);
        logic [11:0] c0, c;
        int n;
        rdCnt(c0);
        c = c0;
        n = 0;
        while (c === c0 && n < 2000) begin
            rdCnt(c);
            n++;
        end
        bound(n, 2000);
        t = $time;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [31:0] r, v;
        logic [11:0] c0, c1;
        logic hw;
        time t0, t1;
        int n, nWarn;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        stopMode = 1'b0;
        deepSleepState = 1'b0;
        lsFreeze = 1'b0;
        nMismatch = 0;
        checksDone = 0;
        mPtr = 1'b0;
        mHold = 1'b0;
        void'($urandom(90463));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(TSWDT_ADDR_PERIOD_SEL, r);
        cmp("period reset", {24'h0, TSWDT_PERIOD_SEL_RESET}, r);
        chkPtr();
        rdCnt(c0);
        cmp("count reset", 32'h0, {20'h0, c0});
        rd(32'h00000000, r);
        cmp("unmapped read", 32'h0, r);
        v = $urandom;
        wr(TSWDT_ADDR_PERIOD_SEL, v);
        rd(TSWDT_ADDR_PERIOD_SEL, r);
        cmp("period readback", {24'h0, v[7:0]}, r);
        wr(TSWDT_ADDR_PERIOD_SEL, 32'h80);
        for (int i = 0; i < 6; i++) begin
            wrKey($urandom);
            chkPtr();
        end
        // a steady tick spacing shows the 128 divide and free counting
        nextTick(t0);
        nextTick(t1);
        n = int'((t1 - t0) / 100);
        cmp("tick gap", 32'h1, {31'h0, (n > 1272 && n < 1288)});
        wrKey(TSWDT_KEY_FIRST);
        wrKey(TSWDT_KEY_SECOND);
        rdCnt(c0);
        cmp("cleared", 32'h1, {31'h0, (c0 < 12'h002)});
        chkPtr();
        repeat (2000) @(posedge clk);
        rdCnt(c0);
        wrKey(TSWDT_KEY_SECOND);
        wrKey(TSWDT_KEY_FIRST);
        rdCnt(c1);
        cmp("no clear wrong key", 32'h1, {31'h0, (c1 >= c0 && c0 != 12'h0)});
        chkPtr();
        stopMode <= 1'b1;
        rdCnt(c0);
        repeat (2000) @(posedge clk);
        rdCnt(c1);
        cmp("stop holds", {20'h0, c0}, {20'h0, c1});
        stopMode <= 1'b0;
        wr(TSWDT_ADDR_PERIOD_SEL, 32'h00);
        deepSleepState <= 1'b1;
        rdCnt(c0);
        repeat (2000) @(posedge clk);
        rdCnt(c1);
        cmp("deep pause", {20'h0, c0}, {20'h0, c1});
        wr(TSWDT_ADDR_PERIOD_SEL, 32'h80);
        repeat (2000) @(posedge clk);
        rdCnt(c0);
        cmp("deep counts", 32'h1, {31'h0, (c0 > c1)});
        deepSleepState <= 1'b0;
        // clear, leave a half sequence open, then let the period run out
        wrKey(TSWDT_KEY_FIRST);
        wrKey(TSWDT_KEY_SECOND);
        wrKey(TSWDT_KEY_FIRST);
        n = 0;
        while (overflowWarningInterrupt !== 1'b1 && n < 50000) begin
            @(negedge clk);
            n++;
        end
        bound(n, 50000);
        hw = haltWakeRequest;
        @(posedge clk);
        lsFreeze <= 1'b1;
        mHold = 1'b1;
        mPtr = 1'b0;
        @(negedge clk);
        cmp("warning pulse", 32'h0, {31'h0, overflowWarningInterrupt});
        cmp("wake", 32'h1, {31'h0, hw});
        chkPtr();
        wrKey(TSWDT_KEY_FIRST);
        chkPtr();
        chkStage(ST_INIT);
        lsFreeze <= 1'b0;
        mHold = 1'b0;
        repeat (30) @(posedge clk);
        chkStage(ST_WARNED);
        n = 0;
        nWarn = 0;
        while (watchdogResetRequest !== 1'b1 && n < 60000) begin
            @(negedge clk);
            if (overflowWarningInterrupt === 1'b1) nWarn++;
            n++;
        end
        bound(n, 60000);
        cmp("second warning", 32'h0, nWarn);
        chkStage(ST_RESET);
        repeat (100) @(posedge clk);
        cmp("reset request held", 32'h1, {31'h0, watchdogResetRequest});
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        mPtr = 1'b0;
        @(negedge clk);
        cmp("reset request cleared", 32'h0, {31'h0, watchdogResetRequest});
        chkPtr();
        chkStage(ST_RUN);
        give_verdict();
    end
endmodule // tb_tswdt_top
